// ==== hdl/alpha_decoder_regs.vh ====
// Constants for the alpha-field decoder
`ifndef ALPHA_DECODER_REGS_VH
`define ALPHA_DECODER_REGS_VH

// Scheme codes in the leading octet, and the padding octet
`define SCHEME_PAIR 8'h80
`define SCHEME_HALF 8'h81
`define SCHEME_FULL 8'h82
`define PAD_OCTET 8'hFF
// Bit position of the offset/default selector
`define SEL_BIT 7

`endif

// ==== hdl/ucs2_alpha_field_decoder.v ====
// Decoder from stored alpha-field octets to 16-bit code points
// Function
// - Leading octet 80h: remaining octets pair into 16-bit characters.
// - Pairwise: first octet of pair is upper half, second is lower half.
// - Leading octet 81h: next octet is the character count.
// - Scheme 81h base is third octet in bits 14..7, others zero.
// - From fourth octet, top bit clear yields a 7-bit default character.
// - Compressed schemes: top bit set yields base plus low seven bits.
// - Leading octet 82h: count then 16-bit base from octets three and four.
// - Scheme 82h characters start at fifth octet, decoded by top bit.
// - All three schemes are supported; 81h offset characters reach at most 7FFFh.
// - Compressed: decode at most count characters; FFh inside count is valid.
`timescale 1ns/100ps
`default_nettype none
`include "alpha_decoder_regs.vh"

// ------------------------------------------------------------
// Decoder
// ------------------------------------------------------------
// Limitations: a single result register sits between the octet side
// and the character side, so a stalled consumer holds in_ready low.
// A count larger than the octets sent ends with the field, not the count.
module ucs2_alpha_field_decoder (
  input wire mclk,
  input wire sys_rst,
  input wire clk_en,
  input wire in_valid,
  input wire [7:0] in_octet,
  input wire in_last,
  output reg in_ready,
  output reg out_valid,
  output reg [15:0] out_char,
  output reg out_default,
  output reg out_last,
  input wire out_ready
);

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [2:0] ST_LEAD = 3'd0;
  localparam [2:0] ST_COUNT = 3'd1;
  localparam [2:0] ST_BASE_HI = 3'd2;
  localparam [2:0] ST_BASE_LO = 3'd3;
  localparam [2:0] ST_BODY = 3'd4;
  localparam [2:0] ST_PAIR_HI = 3'd5;
  localparam [2:0] ST_PAIR_LO = 3'd6;
  localparam [2:0] ST_DRAIN = 3'd7;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [2:0] state_r;
  reg [1:0] scheme_r; // 0 plain, 1 pair, 2 half, 3 full
  reg [7:0] count_r;
  reg [15:0] base_r;
  reg [7:0] upper_code_octet_r;

  // ------------------------------------------------------------
  // Handshake
  // ------------------------------------------------------------
  // Out register is free when empty or being taken this cycle
  wire out_free = !out_valid || out_ready;
  wire take = in_valid && in_ready;

  // ------------------------------------------------------------
  // Character decode shared by compressed schemes and plain text
  // ------------------------------------------------------------
  function [16:0] decode_octet;
    input [7:0] oct;
    input [15:0] base;
    begin
      if (oct[`SEL_BIT])
        decode_octet = {1'b0, base + {9'h000, oct[6:0]}};
      else
        decode_octet = {1'b1, 9'h000, oct[6:0]};
    end
  endfunction

  // Base plus offset may wrap past FFFFh; the writer picks bases that never do
  wire [16:0] dec = decode_octet(in_octet, base_r);

  // ------------------------------------------------------------
  // States whose octet yields no character, except ST_LEAD on a plain-text first octet
  // ------------------------------------------------------------
  // Only character takes need the one-cycle pause, so header
  // octets can still stream back to back.
  function header_state;
    input [2:0] st;
    begin
      case (st)
        ST_LEAD: header_state = 1'b1;
        ST_COUNT: header_state = 1'b1;
        ST_BASE_HI: header_state = 1'b1;
        ST_BASE_LO: header_state = 1'b1;
        ST_PAIR_HI: header_state = 1'b1;
        ST_DRAIN: header_state = 1'b1;
        default: header_state = 1'b0;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Main sequencer
  // ------------------------------------------------------------
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_LEAD;
      scheme_r <= 2'd0;
      count_r <= 8'h00;
      base_r <= 16'h0000;
      upper_code_octet_r <= 8'h00;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_char <= 16'h0000;
      out_default <= 1'b0;
      out_last <= 1'b0;
    end else if (clk_en) begin
      if (out_valid && out_ready)
        out_valid <= 1'b0;
      // Ready only while the output stage can accept a result next cycle
      in_ready <= out_free && !(take && !header_state(state_r));
      if (take) begin
        case (state_r)
          ST_LEAD: begin
            base_r <= 16'h0000;
            if (in_octet == `SCHEME_PAIR) begin
              scheme_r <= 2'd1;
              state_r <= in_last ? ST_LEAD : ST_PAIR_HI;
            end else if (in_octet == `SCHEME_HALF) begin
              scheme_r <= 2'd2;
              state_r <= in_last ? ST_LEAD : ST_COUNT;
            end else if (in_octet == `SCHEME_FULL) begin
              scheme_r <= 2'd3;
              state_r <= in_last ? ST_LEAD : ST_COUNT;
            end else if (in_octet[`SEL_BIT]) begin
              // No coding starts with a top-bit octet: blank padded record
              scheme_r <= 2'd0;
              state_r <= in_last ? ST_LEAD : ST_DRAIN;
            end else begin
              // No prefix: the leading octet is itself a character
              scheme_r <= 2'd0;
              out_valid <= 1'b1;
              out_char <= dec[15:0];
              out_default <= 1'b1;
              out_last <= in_last;
              in_ready <= 1'b0;
              state_r <= in_last ? ST_LEAD : ST_BODY;
            end
          end
          ST_COUNT: begin
            count_r <= in_octet;
            state_r <= in_last ? ST_LEAD : ST_BASE_HI;
          end
          ST_BASE_HI: begin
            if (scheme_r == 2'd2) begin
              base_r <= {1'b0, in_octet, 7'h00};
              state_r <= in_last ? ST_LEAD : (count_r == 8'h00 ? ST_DRAIN : ST_BODY);
            end else begin
              base_r[15:8] <= in_octet;
              state_r <= in_last ? ST_LEAD : ST_BASE_LO;
            end
          end
          ST_BASE_LO: begin
            base_r[7:0] <= in_octet;
            state_r <= in_last ? ST_LEAD : (count_r == 8'h00 ? ST_DRAIN : ST_BODY);
          end
          ST_BODY: begin
            // Plain text has no count and no padding semantics beyond FFh stop
            if (scheme_r == 2'd0 && in_octet == `PAD_OCTET) begin
              if (out_valid && !out_ready)
                out_last <= 1'b0;
              state_r <= in_last ? ST_LEAD : ST_DRAIN;
            end else begin
              out_valid <= 1'b1;
              out_char <= (scheme_r == 2'd0) ? {9'h000, in_octet[6:0]} : dec[15:0];
              out_default <= (scheme_r == 2'd0) ? 1'b1 : dec[16];
              in_ready <= 1'b0;
              if (scheme_r != 2'd0) begin
                count_r <= count_r - 8'h01;
                out_last <= in_last || count_r == 8'h01;
                state_r <= in_last ? ST_LEAD : (count_r == 8'h01 ? ST_DRAIN : ST_BODY);
              end else begin
                out_last <= in_last;
                state_r <= in_last ? ST_LEAD : ST_BODY;
              end
            end
          end
          ST_PAIR_HI: begin
            upper_code_octet_r <= in_octet;
            // Leftover single octet at field end is padding
            state_r <= in_last ? ST_LEAD : ST_PAIR_LO;
          end
          ST_PAIR_LO: begin
            if (upper_code_octet_r == `PAD_OCTET && in_octet == `PAD_OCTET) begin
              state_r <= in_last ? ST_LEAD : ST_DRAIN;
            end else begin
              out_valid <= 1'b1;
              out_char <= {upper_code_octet_r, in_octet};
              out_default <= 1'b0;
              out_last <= in_last;
              in_ready <= 1'b0;
              state_r <= in_last ? ST_LEAD : ST_PAIR_HI;
            end
          end
          ST_DRAIN: begin
            // Swallow trailing padding up to field end
            if (in_last)
              state_r <= ST_LEAD;
          end
          default: state_r <= ST_LEAD;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ==== dv/ucs2_alpha_field_decoder_sva.sv ====
// Port checker for the alpha-field decoder
`timescale 1ns/100ps
`default_nettype none
module ucs2_alpha_field_decoder_sva (
  input wire logic mclk, sys_rst, clk_en, in_valid, in_last, in_ready, out_valid, out_default, out_ready,
  input wire logic [7:0] in_octet,
  input wire logic [15:0] out_char
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [7:0] ld_r, pv_r, n_r, ct_r;
  logic [15:0] bs_r;
  logic st_r;
  wire tk = clk_en && in_valid && in_ready;
  wire [7:0] fs = ld_r[1] ? 8'h04 : 8'h03;
  wire bd = tk && (ld_r == 8'h81 || ld_r == 8'h82) && n_r >= fs && n_r < ct_r + fs;
  wire pl = !(n_r == 8'h00 ? in_octet[7] : ld_r[7]);
  wire pe = ld_r == 8'h80 && !n_r[0] && n_r != 8'h00;
  wire pr = tk && !st_r && pe && {pv_r, in_octet} != 16'hFFFF;
  wire sp = tk && ((pl && in_octet == 8'hFF) || (pe && {pv_r, in_octet} == 16'hFFFF));
  wire qt = tk && n_r != 8'h00 && (ld_r[7] || st_r) && !pr && !bd;
  wire un = tk && !st_r && in_octet != 8'hFF && pl;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {ld_r, pv_r, n_r, ct_r, bs_r} <= '0;
      st_r <= 1'b0;
    end else if (tk) begin
      st_r <= !in_last && (st_r || sp);
      n_r <= in_last ? 8'h00 : n_r + 8'h01;
      pv_r <= in_octet;
      if (n_r == 8'h00) ld_r <= in_octet;
      if (n_r == 8'h01) ct_r <= in_octet;
      if (n_r == 8'h02) bs_r <= ld_r[1] ? {in_octet, 8'h00} : {1'b0, in_octet, 7'h00};
      if (n_r == 8'h03 && ld_r[1]) bs_r[7:0] <= in_octet;
    end
  end
  property p_init; $fell(sys_rst) |-> !out_valid && !in_ready; endproperty
  a_init: assert property (p_init) else $error("not idle");
  property p_lead; tk && n_r == 8'h00 && in_octet[7] |=> !out_valid; endproperty
  a_lead: assert property (p_lead) else $error("lead");
  property p_pair; pr |=> out_valid && !out_default && out_char == {$past(pv_r), pv_r}; endproperty
  a_pair: assert property (p_pair) else $error("pair");
  property p_dflt; (bd || un) && !in_octet[7] |=> out_valid && out_default && out_char == {9'h000, pv_r[6:0]}; endproperty
  a_dflt: assert property (p_dflt) else $error("dflt");
  property p_offs; bd && in_octet[7] |=> out_valid && !out_default && out_char == bs_r + {9'h000, pv_r[6:0]}; endproperty
  a_offs: assert property (p_offs) else $error("offs");
  property p_quiet; qt |=> !out_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("quiet");
  property p_hold; out_valid && !(out_ready && clk_en) |=> out_valid && $stable(out_char); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_busy; out_valid && !out_ready |-> !in_ready; endproperty
  a_busy: assert property (p_busy) else $error("busy");
  c_pair: cover property (pr);
  c_offs: cover property (bd && in_octet[7]);
  c_quiet: cover property (qt);
endmodule
`default_nettype wire

// ==== dv/field_source.sv ====
// Octet source and character sink beside the decoder
`timescale 1ns/100ps
`default_nettype none
module field_source (
  input wire logic mclk, clk_en, slow, in_ready, out_valid, out_default, out_last,
  input wire logic [15:0] out_char,
  output logic in_valid, in_last, out_ready,
  output logic [7:0] in_octet
);
  logic [8:0] fq[$];
  logic [17:0] cq[$];
  logic [7:0] ph = 8'h00;
  logic tk;
  initial {in_valid, in_last, out_ready, in_octet} = '0;
  always @(posedge mclk) begin
    tk = clk_en && in_valid && in_ready;
    if (tk) void'(fq.pop_front());
    if (clk_en && out_valid && out_ready) cq.push_back({out_last, out_default, out_char});
    ph = ph + 8'h01;
    #1;
    if (tk || !in_valid) in_valid = fq.size() > 0 && !(slow && ph[1]);
    if (in_valid) {in_last, in_octet} = fq[0];
    else {in_last, in_octet} = ~{in_last, in_octet};
    out_ready = !(slow && ph[2]);
  end
endmodule
`default_nettype wire

// ==== dv/ucs2_alpha_field_decoder_tb.sv ====
// Self-checking bench for the alpha-field decoder
`timescale 1ns/100ps
`default_nettype none
module ucs2_alpha_field_decoder_tb;
  logic mclk = 0, sys_rst = 1, clk_en = 1, gate = 0, slow = 0;
  logic in_valid, in_last, in_ready, out_valid, out_default, out_last, out_ready;
  logic [7:0] in_octet;
  logic [15:0] out_char;
  int num_errors = 0, checks_done = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) #1 clk_en = !(gate && clk_en);
  ucs2_alpha_field_decoder uut (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .in_valid(in_valid), .in_octet(in_octet),
    .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid), .out_char(out_char),
    .out_default(out_default), .out_last(out_last), .out_ready(out_ready)
  );
  field_source u_src (
    .mclk(mclk), .clk_en(clk_en), .slow(slow), .in_ready(in_ready), .out_valid(out_valid),
    .out_default(out_default), .out_last(out_last), .out_char(out_char), .in_valid(in_valid),
    .in_last(in_last), .out_ready(out_ready), .in_octet(in_octet)
  );
  task automatic check(input string nm, input logic [17:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Expected chars are 5 hex digits: flags (2 last, 1 default) then code
  task automatic run(input string nm, input logic [71:0] f, input int nf, input logic [99:0] e, input int ne);
    int i;
    for (i = nf - 1; i >= 0; i--) u_src.fq.push_back({i == 0, f[8 * i +: 8]});
    for (i = 0; i < 500 && (u_src.cq.size() < ne || u_src.fq.size() > 0); i++) @(posedge mclk);
    if (i == 500) begin
      num_errors++;
      results();
    end
    repeat (8) @(posedge mclk);
    check(nm, 18'(u_src.cq.size()), 18'(ne));
    for (i = ne - 1; i >= 0; i--) begin
      check(nm, u_src.cq.size() > 0 ? u_src.cq.pop_front() : 18'h3FFFF, e[20 * i +: 18]);
    end
    $display("%s done", nm);
  endtask
  task automatic t_pair();
    run("pair", 72'h80_1234_ABCD_FFFF_FF, 8, 100'h01234_0ABCD, 2);
  endtask
  task automatic t_plain();
    run("plain", 72'h4849, 2, 100'h10048_30049, 2);
    run("empty", 72'h81_0020, 3, 100'h0, 0);
    run("stop", 72'h41FF42, 3, 100'h10041, 1);
    run("blank", 72'hFFFF, 2, 100'h0, 0);
  endtask
  task automatic t_half();
    run("half", 72'h81_0513_5395_A641_FFFF, 9, 100'h10053_00995_009A6_10041_209FF, 5);
  endtask
  task automatic t_full();
    run("full", 72'h82_0505_302D_82D3_2D31, 9, 100'h1002D_00532_00583_1002D_30031, 5);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    #1 sys_rst = 0;
    repeat (2) @(posedge mclk);
    t_pair();
    t_plain();
    #1 slow = 1;
    gate = 1;
    t_half();
    t_full();
    results();
  end
endmodule
bind ucs2_alpha_field_decoder ucs2_alpha_field_decoder_sva u_sva (
  .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .in_valid(in_valid), .in_last(in_last),
  .in_ready(in_ready), .out_valid(out_valid), .out_default(out_default), .out_ready(out_ready),
  .in_octet(in_octet), .out_char(out_char)
);
`default_nettype wire
